/* File: design/dahcr_seq.sv */
// Conversion cycle sequencer paced by half periods of the conversion clock.
`default_nettype none
`include "dahcr_params.svh"
module dahcr_seq (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic start,
    input wire logic half_tick,
    output var logic busy_n,
    output var logic latch,
    output var logic release_hold,
    output logic ready
);
    localparam int LATCH_H = `DAHCR_LATCH_HALVES;
    localparam int BUSY_H = `DAHCR_BUSY_HALVES;
    localparam int CONV_H = `DAHCR_CONV_HALVES;
    localparam int TOTAL_H = `DAHCR_TOTAL_HALVES;
    dahcr_pkg::dahcr_state_t state;
    logic [5:0] cnt;
    logic [5:0] next_cnt;

    assign next_cnt = cnt + 6'h01;
    assign ready = (state == dahcr_pkg::dahcr_st_idle);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= dahcr_pkg::dahcr_st_idle;
            cnt <= 6'h00;
        end else if (ce) begin
            case (state)
                dahcr_pkg::dahcr_st_idle: begin
                    cnt <= 6'h00;
                    if (start) begin
                        state <= dahcr_pkg::dahcr_st_conv;
                    end
                end
                dahcr_pkg::dahcr_st_conv: begin
                    if (half_tick) begin
                        cnt <= next_cnt;
                        if (next_cnt == 6'(CONV_H)) begin
                            state <= dahcr_pkg::dahcr_st_acq;
                        end
                    end
                end
                dahcr_pkg::dahcr_st_acq: begin
                    if (half_tick) begin
                        cnt <= next_cnt;
                        if (next_cnt == 6'(TOTAL_H)) begin
                            state <= dahcr_pkg::dahcr_st_idle;
                        end
                    end
                end
                default: begin
                    state <= dahcr_pkg::dahcr_st_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_n <= 1'b1;
        end else if (ce) begin
            if (ready && start) begin
                busy_n <= 1'b0;
            end else if (state == dahcr_pkg::dahcr_st_conv && half_tick &&
                         next_cnt == 6'(BUSY_H)) begin
                busy_n <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            latch <= 1'b0;
            release_hold <= 1'b0;
        end else if (ce) begin
            latch <= (state == dahcr_pkg::dahcr_st_conv) && half_tick && next_cnt == 6'(LATCH_H);
            release_hold <= (state == dahcr_pkg::dahcr_st_conv) && half_tick &&
                            next_cnt == 6'(BUSY_H);
        end
    end

    sequence conv_begin;
        ce && ready && start;
    endsequence
    sequence busy_low_next;
        !busy_n && state == dahcr_pkg::dahcr_st_conv;
    endsequence
    property busy_follows_start;
        @(posedge clk) disable iff (!reset_n) conv_begin |=> busy_low_next;
    endproperty
    busy_start_a: assert property (busy_follows_start) else $error("busy not low after start");
    busy_in_conv_a: assert property (@(posedge clk) disable iff (!reset_n)
        !busy_n |-> state == dahcr_pkg::dahcr_st_conv)
        else $error("busy low outside conversion");
    latch_time_a: assert property (@(posedge clk) disable iff (!reset_n)
        latch |-> cnt == 6'(LATCH_H) && !busy_n) else $error("latch at wrong count");
    cycle_end_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && state == dahcr_pkg::dahcr_st_acq && half_tick && cnt == 6'(TOTAL_H - 1)
        |=> ready) else $error("cycle length wrong");
endmodule
`default_nettype wire

/* File: design/dahcr_top.sv */
// Hold strobe queue, result registers and parallel readout of the dual converter.
// Summary of operation
// - A pair strobe falling holds both channels of that pair and starts conversion.
// - Busy goes low at conversion start and returns high 26 half periods later, two before conversion ends.
// - Read and chip select both low put the result word on the output bus.
// - Each cycle spends 1.75 us converting and 0.25 us acquiring at 8 MHz.
// - The conversion clock paces conversions, one result per converter every 2 us.
// - Reads are served while the next conversion is already running.
// - Each of the three pairs has its own independent hold strobe.
// - Strobes pick the input mux pair; all three together sample all six inputs.
// - Results are stored in six output registers.
// - A read word holds valid flag, 3-bit channel address and 12-bit result.
// - Select bits choose single channel, cycle or FIFO read order.
// - FIFO mode lets one pair fill all six registers, three per channel.
// - Pairs held in one cycle convert A, then B, then C; later ones queue.
// - Further strobe falls are ignored until that pair's hold releases as busy returns high, or reset.
// - New results enter their register 12.5 conversion clocks after busy falls.
// - Reset clears the registers, aborts conversion and returns switches to sampling.
`default_nettype none
`include "dahcr_params.svh"
module dahcr_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic conv_clk_pin,
    input wire logic pair_a_sample_strobe_n,
    input wire logic pair_b_sample_strobe_n,
    input wire logic pair_c_sample_strobe_n,
    input wire logic rd_n,
    input wire logic cs_n,
    input wire logic sel_bit0,
    input wire logic sel_bit1,
    input wire logic sel_bit2,
    input wire logic [11:0] adc0_code,
    input wire logic [11:0] adc1_code,
    output logic busy_n,
    output var logic [2:0] pair_hold,
    output var logic [1:0] conv_pair_sel,
    output var logic [15:0] data_out,
    output var logic data_oe_n
);
    logic [35:0] sync1;
    logic [35:0] sync2;
    logic [2:0] hold_q;
    logic clk_q;
    logic act_q;
    logic [2:0] fall;
    logic [2:0] accept;
    logic half_tick;
    logic act;
    logic rd_start;
    logic rd_end;
    logic [1:0] q [0:2];
    logic [1:0] next_q [0:2];
    logic [1:0] len;
    logic [1:0] next_len;
    logic start;
    logic seq_ready;
    logic latch;
    logic release_hold;
    dahcr_pkg::dahcr_word_t word [0:`DAHCR_NUM_REGS-1];
    dahcr_pkg::dahcr_mode_t wr_mode;
    dahcr_pkg::dahcr_mode_t rd_mode;
    dahcr_pkg::dahcr_mode_t next_rd_mode;
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    logic [2:0] fifo_cnt;
    logic [2:0] cyc_ptr;
    logic [2:0] idx0;
    logic [2:0] idx1;
    logic do_wr;
    logic [2:0] rd_idx;
    logic [2:0] start_idx;
    logic [2:0] cur_idx;

    function automatic dahcr_pkg::dahcr_mode_t dahcr_decode(input logic [2:0] sel);
        case (sel)
            `DAHCR_SEL_CYCLE: dahcr_decode = dahcr_pkg::dahcr_md_cycle;
            `DAHCR_SEL_FIFO: dahcr_decode = dahcr_pkg::dahcr_md_fifo;
            default: dahcr_decode = dahcr_pkg::dahcr_md_single;
        endcase
    endfunction

    function automatic logic [2:0] dahcr_wrap(input logic [2:0] p, input logic [2:0] step);
        logic [3:0] s;
        s = {1'b0, p} + {1'b0, step};
        dahcr_wrap = (s > 4'(`DAHCR_LAST_REG)) ? 3'(s - 4'h6) : s[2:0];
    endfunction

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1 <= `DAHCR_SYNC_RST;
            sync2 <= `DAHCR_SYNC_RST;
        end else if (ce) begin
            sync1 <= {3'h0, conv_clk_pin, rd_n, cs_n, pair_c_sample_strobe_n,
                      pair_b_sample_strobe_n, pair_a_sample_strobe_n, sel_bit2, sel_bit1,
                      sel_bit0, adc1_code, adc0_code};
            sync2 <= sync1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_q <= 3'h7;
            clk_q <= 1'b0;
            act_q <= 1'b0;
        end else if (ce) begin
            hold_q <= sync2[29:27];
            clk_q <= sync2[32];
            act_q <= act;
        end
    end

    assign half_tick = sync2[32] ^ clk_q;
    assign fall = hold_q & ~sync2[29:27];
    assign accept = fall & ~pair_hold;
    assign act = !sync2[31] && !sync2[30];
    assign rd_start = act && !act_q;
    assign rd_end = !act && act_q;
    assign start = ce && seq_ready && (len != 2'h0);

    // Queue in A, B, C order.
    always_comb begin
        next_q = q;
        next_len = len;
        if (start) begin
            next_q[0] = q[1];
            next_q[1] = q[2];
            next_q[2] = 2'h0;
            next_len = len - 2'h1;
        end
        for (int i = 0; i < `DAHCR_NUM_PAIRS; i++) begin
            if (accept[i] && next_len < 2'h3) begin
                next_q[next_len] = 2'(i);
                next_len = next_len + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 3; i++) begin
                q[i] <= 2'h0;
            end
            len <= 2'h0;
            conv_pair_sel <= 2'h0;
        end else if (ce) begin
            q <= next_q;
            len <= next_len;
            if (start) begin
                conv_pair_sel <= q[0];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pair_hold <= 3'h0;
        end else if (ce) begin
            for (int i = 0; i < `DAHCR_NUM_PAIRS; i++) begin
                if (accept[i]) begin
                    pair_hold[i] <= 1'b1;
                end else if (release_hold && conv_pair_sel == 2'(i)) begin
                    pair_hold[i] <= 1'b0;
                end
            end
        end
    end

    dahcr_seq u_seq (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .start(start),
        .half_tick(half_tick),
        .busy_n(busy_n),
        .latch(latch),
        .release_hold(release_hold),
        .ready(seq_ready)
    );

    assign wr_mode = dahcr_decode(sync2[26:24]);
    assign next_rd_mode = dahcr_decode(sync2[26:24]);
    assign idx0 = (wr_mode == dahcr_pkg::dahcr_md_fifo) ? wr_ptr : {conv_pair_sel, 1'b0};
    assign idx1 = idx0 + 3'h1;
    assign do_wr = ce && latch &&
                   (wr_mode != dahcr_pkg::dahcr_md_fifo || fifo_cnt <= `DAHCR_FIFO_ROOM);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int r = 0; r < `DAHCR_NUM_REGS; r++) begin
                word[r] <= 16'h0000;
            end
        end else if (ce) begin
            for (int r = 0; r < `DAHCR_NUM_REGS; r++) begin
                if (do_wr && idx0 == 3'(r)) begin
                    word[r] <= {1'b1, conv_pair_sel, 1'b0, sync2[11:0]};
                end else if (do_wr && idx1 == 3'(r)) begin
                    word[r] <= {1'b1, conv_pair_sel, 1'b1, sync2[23:12]};
                end else if (rd_end && rd_idx == 3'(r)) begin
                    word[r][15] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            fifo_cnt <= 3'h0;
        end else if (ce) begin
            if (do_wr && wr_mode == dahcr_pkg::dahcr_md_fifo) begin
                wr_ptr <= dahcr_wrap(wr_ptr, 3'h2);
            end
            if (rd_end && rd_mode == dahcr_pkg::dahcr_md_fifo && fifo_cnt != 3'h0) begin
                rd_ptr <= dahcr_wrap(rd_ptr, 3'h1);
            end
            fifo_cnt <= fifo_cnt
                + ((do_wr && wr_mode == dahcr_pkg::dahcr_md_fifo) ? 3'h2 : 3'h0)
                - ((rd_end && rd_mode == dahcr_pkg::dahcr_md_fifo && fifo_cnt != 3'h0)
                   ? 3'h1 : 3'h0);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cyc_ptr <= 3'h0;
        end else if (ce && rd_end && rd_mode == dahcr_pkg::dahcr_md_cycle) begin
            cyc_ptr <= dahcr_wrap(cyc_ptr, 3'h1);
        end
    end

    always_comb begin
        case (next_rd_mode)
            dahcr_pkg::dahcr_md_cycle: start_idx = cyc_ptr;
            dahcr_pkg::dahcr_md_fifo: start_idx = rd_ptr;
            default: start_idx = sync2[26:24];
        endcase
    end
    assign cur_idx = rd_start ? start_idx : rd_idx;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_idx <= 3'h0;
            rd_mode <= dahcr_pkg::dahcr_md_single;
            data_out <= 16'h0000;
            data_oe_n <= 1'b1;
        end else if (ce) begin
            if (rd_start) begin
                rd_idx <= start_idx;
                rd_mode <= next_rd_mode;
            end
            if (act) begin
                data_out <= word[cur_idx];
            end
            data_oe_n <= !act;
        end
    end

    default clocking dahcr_cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    hold_set_a: assert property (ce && accept[0] |=> pair_hold[0])
        else $error("pair A not held");
    ignore_refall_a: assert property (ce && fall[0] && pair_hold[0]
        && accept[2:1] == 2'h0 |=> len == $past(len) - 2'($past(start)))
        else $error("refall accepted");
    order_abc_a: assert property (ce && accept == 3'h7 && len == 2'h0 && !start
        |=> q[0] == 2'h0 && q[1] == 2'h1 && q[2] == 2'h2)
        else $error("queue order wrong");
    indep_pair_a: assert property (ce && fall == 3'h4 && !pair_hold[2] && !release_hold
        |=> pair_hold[2] && pair_hold[1:0] == $past(pair_hold[1:0]))
        else $error("pair C not independent");
    store_reg_a: assert property (do_wr
        |=> word[$past(idx0)][15] && word[$past(idx1)][15])
        else $error("result not stored");
    word_form_a: assert property (!data_oe_n && data_out[15]
        |-> data_out[14:12] <= 3'h5)
        else $error("bad channel address");
    cycle_step_a: assert property (ce && rd_end && rd_mode == dahcr_pkg::dahcr_md_cycle
        |=> cyc_ptr == (($past(cyc_ptr) == 3'h5) ? 3'h0 : $past(cyc_ptr) + 3'h1))
        else $error("cycle pointer wrong");
    fifo_depth_a: assert property (fifo_cnt <= 3'h6)
        else $error("fifo over six");
    overlap_read_a: assert property (ce && act && !busy_n |=> !data_oe_n)
        else $error("read blocked by busy");
endmodule
`default_nettype wire

/* File: pkg/dahcr_params.svh */
// Constants for the dual converter hold, convert and readout block.
`ifndef DAHCR_PARAMS_SVH
`define DAHCR_PARAMS_SVH

`define DAHCR_CLK_NS 8
`define DAHCR_HOLD_MIN_NS 15
`define DAHCR_HOLD_MIN_CYC ((`DAHCR_HOLD_MIN_NS + `DAHCR_CLK_NS - 1) / `DAHCR_CLK_NS)
`define DAHCR_CONV_CLK_NS 125
`define DAHCR_CONV_TIME_NS 1750
`define DAHCR_ACQ_TIME_NS 250
`define DAHCR_LATCH_HALVES 25
`define DAHCR_BUSY_HALVES 26
`define DAHCR_CONV_HALVES ((2 * `DAHCR_CONV_TIME_NS) / `DAHCR_CONV_CLK_NS)
`define DAHCR_TOTAL_HALVES (`DAHCR_CONV_HALVES + (2 * `DAHCR_ACQ_TIME_NS) / `DAHCR_CONV_CLK_NS)
`define DAHCR_NUM_PAIRS 3
`define DAHCR_NUM_REGS 6
`define DAHCR_DATA_W 12
`define DAHCR_SEL_CYCLE 3'h6
`define DAHCR_SEL_FIFO 3'h7
`define DAHCR_LAST_REG 3'h5
`define DAHCR_FIFO_ROOM 3'h4
`define DAHCR_SYNC_RST 36'h0F8000000

`endif

/* File: pkg/dahcr_pkg.sv */
// Types for the dual converter hold, convert and readout block.
`default_nettype none
package dahcr_pkg;
    typedef enum logic [2:0] {
        dahcr_st_idle = 3'h1,
        dahcr_st_conv = 3'h2,
        dahcr_st_acq = 3'h4
    } dahcr_state_t;
    typedef enum logic [2:0] {
        dahcr_md_single = 3'h1,
        dahcr_md_cycle = 3'h2,
        dahcr_md_fifo = 3'h4
    } dahcr_mode_t;
    typedef logic [15:0] dahcr_word_t;
endpackage
`default_nettype wire

/* File: verification/dahcr_host.sv */
// Host controller and converter front end model facing the readout block.
`default_nettype none
module dahcr_host (
    input wire logic clk,
    input wire logic [1:0] conv_pair_sel,
    input wire logic [15:0] data_out,
    input wire logic data_oe_n,
    output var logic conv_clk_pin,
    output var logic pair_a_sample_strobe_n,
    output var logic pair_b_sample_strobe_n,
    output var logic pair_c_sample_strobe_n,
    output var logic rd_n,
    output var logic cs_n,
    output var logic sel_bit0,
    output var logic sel_bit1,
    output var logic sel_bit2,
    output var logic [11:0] adc0_code,
    output var logic [11:0] adc1_code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] code_tag;
    initial begin
        code_tag = 6'h00;
        conv_clk_pin = 1'b0;
        {pair_c_sample_strobe_n, pair_b_sample_strobe_n, pair_a_sample_strobe_n} = 3'h7;
        rd_n = 1'b1;
        cs_n = 1'b1;
        {sel_bit2, sel_bit1, sel_bit0} = 3'h0;
        adc0_code = 12'h000;
        adc1_code = 12'h000;
    end
    // The conversion clock runs free, four system clocks per half period.
    always #32 conv_clk_pin = ~conv_clk_pin;
    // Each converter returns a code that names the pair being converted.
    always @(negedge clk) begin
        adc0_code <= {4'hA, code_tag, conv_pair_sel};
        adc1_code <= {4'h5, code_tag, conv_pair_sel};
    end
    task automatic set_tag(input logic [5:0] t);
        @(negedge clk);
        code_tag = t;
    endtask
    task automatic select(input logic rd_lvl, input logic cs_lvl);
        @(negedge clk);
        rd_n = rd_lvl;
        cs_n = cs_lvl;
    endtask
    task automatic set_mode(input logic [2:0] mode);
        @(negedge clk);
        {sel_bit2, sel_bit1, sel_bit0} = mode;
    endtask
    task automatic strobe(input logic [2:0] pairs);
        @(negedge clk);
        {pair_c_sample_strobe_n, pair_b_sample_strobe_n, pair_a_sample_strobe_n} = ~pairs;
        repeat (4) @(negedge clk);
        {pair_c_sample_strobe_n, pair_b_sample_strobe_n, pair_a_sample_strobe_n} = 3'h7;
    endtask
    task automatic read_word(input logic [2:0] mode, output logic [15:0] word, output logic hung);
        int n;
        set_mode(mode);
        repeat (2) @(negedge clk);
        rd_n = 1'b0;
        cs_n = 1'b0;
        n = 0;
        while (data_oe_n !== 1'b0 && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        word = data_out;
        rd_n = 1'b1;
        cs_n = 1'b1;
        while (data_oe_n !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        hung = (n >= 20);
        repeat (2) @(negedge clk);
    endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the dual converter hold, convert and readout block.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, ce, conv_clk_pin, rd_n, cs_n, sel_bit0, sel_bit1, sel_bit2, busy_n;
    logic pa_n, pb_n, pc_n, data_oe_n;
    logic [11:0] adc0_code, adc1_code;
    logic [2:0] pair_hold;
    logic [1:0] conv_pair_sel;
    logic [15:0] data_out;
    int miscompares = 0;
    int checked = 0;
    dahcr_top u_dahcr_top (.clk(clk), .reset_n(reset_n), .ce(ce), .conv_clk_pin(conv_clk_pin),
        .pair_a_sample_strobe_n(pa_n), .pair_b_sample_strobe_n(pb_n),
        .pair_c_sample_strobe_n(pc_n), .rd_n(rd_n), .cs_n(cs_n), .sel_bit0(sel_bit0),
        .sel_bit1(sel_bit1), .sel_bit2(sel_bit2), .adc0_code(adc0_code), .adc1_code(adc1_code),
        .busy_n(busy_n), .pair_hold(pair_hold), .conv_pair_sel(conv_pair_sel),
        .data_out(data_out), .data_oe_n(data_oe_n));
    dahcr_host u_dahcr_host (.clk(clk), .conv_pair_sel(conv_pair_sel), .data_out(data_out),
        .data_oe_n(data_oe_n), .conv_clk_pin(conv_clk_pin), .pair_a_sample_strobe_n(pa_n),
        .pair_b_sample_strobe_n(pb_n), .pair_c_sample_strobe_n(pc_n), .rd_n(rd_n),
        .cs_n(cs_n), .sel_bit0(sel_bit0), .sel_bit1(sel_bit1), .sel_bit2(sel_bit2),
        .adc0_code(adc0_code), .adc1_code(adc1_code));
    always #4 clk = ~clk;
    function automatic logic [15:0] exp_word(input int p, input int k, input logic [5:0] t);
        logic [1:0] ps;
        ps = 2'(p);
        return {1'b1, ps, k[0], k[0] ? {4'h5, t, ps} : {4'hA, t, ps}};
    endfunction
    task automatic give_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic check_range(input int got, input int lo, input int hi, input string what);
        checked++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %0d range %0d..%0d", $time, what, got, lo, hi);
        end
    endtask
    task automatic wait_busy(input logic level, output int n);
        n = 0;
        while (busy_n !== level && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (n >= 400) begin
            miscompares++;
            $display("CHECK FAILED at %0t: busy wait ran out", $time);
            give_verdict();
        end
    endtask
    task automatic rd(input logic [2:0] mode, output logic [15:0] w);
        logic hung;
        u_dahcr_host.read_word(mode, w, hung);
        if (hung) begin
            miscompares++;
            $display("CHECK FAILED at %0t: read not answered", $time);
            give_verdict();
        end
    endtask
    task automatic stay_idle(input int cycles);
        int bad;
        bad = 0;
        repeat (cycles) begin
            @(negedge clk);
            if (busy_n !== 1'b1) bad++;
        end
        check_range(bad, 0, 0, "busy while idle");
    endtask
    task automatic do_reset();
        @(negedge clk);
        reset_n = 1'b0;
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask
    task automatic test_reset();
        int n;
        logic [15:0] w;
        check_word({12'h000, busy_n, pair_hold}, 16'h0008, "idle after reset");
        rd(3'h0, w);
        check_word({15'h0000, w[15]}, 16'h0000, "cleared word");
        u_dahcr_host.strobe(3'h4);
        wait_busy(1'b0, n);
        @(negedge clk);
        reset_n = 1'b0;
        #1;
        check_word({11'h000, busy_n, data_oe_n, pair_hold}, 16'h0018, "abort");
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        stay_idle(200);
        rd(3'h4, w);
        check_word({15'h0000, w[15]}, 16'h0000, "no result after abort");
        $display("test_reset done");
    endtask
    task automatic test_single();
        int n;
        logic [15:0] w;
        u_dahcr_host.set_tag(6'h2A);
        u_dahcr_host.strobe(3'h1);
        wait_busy(1'b0, n);
        check_word({11'h000, conv_pair_sel, pair_hold}, 16'h0001, "pair A held");
        wait_busy(1'b1, n);
        check_range(n, 100, 108, "busy low length");
        u_dahcr_host.strobe(3'h1);
        wait_busy(1'b0, n);
        check_range(n + 5, 20, 30, "acquisition gap");
        rd(3'h0, w);
        check_word(w, exp_word(0, 0, 6'h2A), "read during conversion");
        check_word({15'h0000, busy_n}, 16'h0000, "read overlapped");
        wait_busy(1'b1, n);
        for (int k = 0; k < 2; k++) begin
            rd(3'(k), w);
            check_word(w, exp_word(0, k, 6'h2A), "single channel read");
        end
        $display("test_single done");
    endtask
    task automatic test_select();
        int bad;
        bad = 0;
        for (int s = 1; s < 3; s++) begin
            u_dahcr_host.select(s[0], s[1]);
            repeat (8) begin
                @(negedge clk);
                if (data_oe_n !== 1'b1) bad++;
            end
        end
        u_dahcr_host.select(1'b1, 1'b1);
        check_range(bad, 0, 0, "output without both selects");
        $display("test_select done");
    endtask
    task automatic test_ce();
        int n;
        u_dahcr_host.strobe(3'h2);
        wait_busy(1'b0, n);
        @(negedge clk);
        ce = 1'b0;
        repeat (60) @(negedge clk);
        check_word({12'h000, busy_n, pair_hold}, 16'h0002, "frozen while disabled");
        ce = 1'b1;
        wait_busy(1'b1, n);
        check_range(n + 61, 156, 172, "busy stretched by enable");
        $display("test_ce done");
    endtask
    task automatic test_queue();
        int n;
        time t0;
        logic [15:0] w;
        logic [2:0] hx;
        do_reset();
        u_dahcr_host.strobe(3'h7);
        for (int p = 0; p < 3; p++) begin
            wait_busy(1'b0, n);
            if (p > 0) check_range(int'(($time - t0) / 8), 124, 132, "start spacing");
            t0 = $time;
            hx = 3'h7 << p;
            check_word({14'h0000, conv_pair_sel}, 16'(p), "pair order");
            check_word({13'h0000, pair_hold}, {13'h0000, hx}, "pairs held");
            if (p == 0) u_dahcr_host.strobe(3'h1);
            wait_busy(1'b1, n);
        end
        stay_idle(200);
        for (int i = 0; i < 6; i++) begin
            rd(3'h6, w);
            check_word(w, exp_word(i / 2, i % 2, 6'h2A), "cycle read");
        end
        rd(3'h6, w);
        check_word(w, exp_word(0, 0, 6'h2A) & 16'h7FFF, "cycle wrap");
        $display("test_queue done");
    endtask
    task automatic test_fifo();
        int n;
        logic [15:0] w;
        do_reset();
        u_dahcr_host.set_mode(3'h7);
        for (int t = 1; t < 5; t++) begin
            u_dahcr_host.set_tag(6'(t));
            u_dahcr_host.strobe(3'h2);
            wait_busy(1'b0, n);
            wait_busy(1'b1, n);
        end
        for (int i = 0; i < 6; i++) begin
            rd(3'h7, w);
            check_word(w, exp_word(1, i % 2, 6'(i / 2 + 1)), "fifo read");
        end
        rd(3'h7, w);
        check_word({15'h0000, w[15]}, 16'h0000, "fifo empty");
        $display("test_fifo done");
    endtask
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        ce = 1'b1;
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        test_reset();
        test_select();
        test_single();
        test_ce();
        test_queue();
        test_fifo();
        give_verdict();
    end
endmodule
`default_nettype wire
